// ---- rtl/qfr_dev.sv ----
/*
  Flash end of the quad I/O read path: decodes the read command in either
  command mode, takes a 24-bit address on four lines, counts dummy clocks
  and streams array bytes on four lines until chip select rises.
  Assumes the array sits outside: byte at mem_addr is valid on mem_data one
  core cycle after mem_addr changes. Link pins are asynchronous to core_clk.
*/
`timescale 1ns/1ns
module qfr_dev
  import qfr_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  qfr_if.dev                         lnk,
  input  wire logic                  quad_enable_bit,
  input  wire logic                  four_line_command_mode,
  input  wire logic                  dummy_select_lo,
  input  wire logic                  dummy_select_hi,
  input  wire logic                  write_busy,
  input  wire logic [7:0]            mem_data,
  output logic      [QFR_ADDR_W-1:0] mem_addr,
  output logic                       read_active,
  output logic                       cmd_reject
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] cs_s_q;
  logic [2:0] ck_s_q;
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;
  logic       cs_hi;
  logic       ck_rise;
  logic       ck_fall;

  // third stage only feeds the edge detector; stage one feeds stage two alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_s_q  <= 3'h7;
      ck_s_q  <= 3'h0;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      cs_s_q  <= {cs_s_q[1:0], lnk.cs_n};
      ck_s_q  <= {ck_s_q[1:0], lnk.sclk};
      io_s1_q <= lnk.io_line;
      io_s2_q <= io_s1_q;
    end
  end

  assign cs_hi   = cs_s_q[1];
  assign ck_rise = ck_s_q[1] & ~ck_s_q[2];
  assign ck_fall = ~ck_s_q[1] & ck_s_q[2];

  // ****************************************
  // dummy count lookup
  // ****************************************
  function automatic logic [3:0] dummy_of(input logic hi, input logic lo);
    logic [3:0] n;
    unique case ({hi, lo})
      2'b00:   n = QFR_DUMMY_SEL0;
      2'b01:   n = QFR_DUMMY_SEL1;
      2'b10:   n = QFR_DUMMY_SEL2;
      default: n = QFR_DUMMY_SEL3;
    endcase
    return n;
  endfunction

  // ****************************************
  // transfer state
  // ****************************************
  qfr_phase_t            st_q;
  qfr_phase_t            st_d;
  logic [3:0]            cnt_q;
  logic [3:0]            cnt_d;
  logic [7:0]            cmd_q;
  logic [7:0]            cmd_d;
  logic                  four_q;
  logic                  four_d;
  logic [3:0]            dum_q;
  logic [3:0]            dum_d;
  logic [QFR_ADDR_W-1:0] addr_q;
  logic [QFR_ADDR_W-1:0] addr_d;
  logic                  nib_hi_q;
  logic                  nib_hi_d;
  logic [7:0]            byte_q;
  logic [7:0]            byte_d;
  logic [3:0]            io_o_q;
  logic [3:0]            io_o_d;
  logic [3:0]            io_oe_q;
  logic [3:0]            io_oe_d;
  logic                  rej_q;
  logic                  rej_d;
  logic                  act_q;
  logic                  act_d;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    cmd_d    = cmd_q;
    four_d   = four_q;
    dum_d    = dum_q;
    addr_d   = addr_q;
    nib_hi_d = nib_hi_q;
    byte_d   = byte_q;
    io_o_d   = io_o_q;
    io_oe_d  = io_oe_q;
    rej_d    = 1'b0;
    if (cs_hi) begin
      // frame over: release the lines whatever the phase
      st_d    = QFR_IDLE;
      io_oe_d = 4'h0;
    end else begin
      unique case (st_q)
        QFR_IDLE: begin
          st_d   = QFR_CMD;
          cnt_d  = 4'h0;
          cmd_d  = 8'h00;
          four_d = four_line_command_mode;
        end
        QFR_CMD: begin
          if (ck_rise) begin
            if (four_q) begin
              cmd_d = {cmd_q[3:0], io_s2_q};
            end else begin
              cmd_d = {cmd_q[6:0], io_s2_q[0]};
            end
            cnt_d = cnt_q + 4'h1;
            if (cnt_d == (four_q ? QFR_CMD_CLK_4 : QFR_CMD_CLK_1)) begin
              cnt_d = 4'h0;
              if (cmd_d != QFR_READ_CMD) begin
                // other commands belong to other blocks; stay off the lines
                st_d = QFR_DONE;
              end else if (!quad_enable_bit || write_busy) begin
                st_d  = QFR_DONE;
                rej_d = 1'b1;
              end else begin
                st_d = QFR_ADDR;
              end
            end
          end
        end
        QFR_ADDR: begin
          if (ck_rise) begin
            addr_d = {addr_q[QFR_ADDR_W-5:0], io_s2_q};
            cnt_d  = cnt_q + 4'h1;
            if (cnt_d == QFR_ADDR_CLK) begin
              cnt_d = 4'h0;
              st_d  = QFR_DUMMY;
              dum_d = dummy_of(dummy_select_hi, dummy_select_lo);
            end
          end
        end
        QFR_DUMMY: begin
          if (ck_rise) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_d == dum_q) begin
              cnt_d    = 4'h0;
              st_d     = QFR_DATA;
              nib_hi_d = 1'b1;
            end
          end
        end
        QFR_DATA: begin
          if (ck_fall) begin
            io_oe_d  = 4'hF;
            nib_hi_d = ~nib_hi_q;
            if (nib_hi_q) begin
              byte_d = mem_data;
              io_o_d = mem_data[7:4];
            end else begin
              io_o_d = byte_q[3:0];
              // natural 24-bit rollover takes the top address back to zero
              addr_d = addr_q + 24'h00_0001;
            end
          end
        end
        QFR_DONE: begin
          st_d = QFR_DONE;
        end
        default: begin
          st_d = QFR_IDLE;
        end
      endcase
    end
    act_d = (st_d == QFR_DATA);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q     <= QFR_IDLE;
      cnt_q    <= 4'h0;
      cmd_q    <= 8'h00;
      four_q   <= 1'b0;
      dum_q    <= QFR_DUMMY_SEL0;
      addr_q   <= 24'h00_0000;
      nib_hi_q <= 1'b1;
      byte_q   <= 8'h00;
      io_o_q   <= 4'h0;
      io_oe_q  <= 4'h0;
      rej_q    <= 1'b0;
      act_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      cmd_q    <= cmd_d;
      four_q   <= four_d;
      dum_q    <= dum_d;
      addr_q   <= addr_d;
      nib_hi_q <= nib_hi_d;
      byte_q   <= byte_d;
      io_o_q   <= io_o_d;
      io_oe_q  <= io_oe_d;
      rej_q    <= rej_d;
      act_q    <= act_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign lnk.dev_io_o  = io_o_q;
  assign lnk.dev_io_oe = io_oe_q;
  assign mem_addr      = addr_q;
  assign read_active   = act_q;
  assign cmd_reject    = rej_q;

endmodule

// ---- common/qfr_pkg.sv ----
/*
  Shared constants and types for the quad I/O flash read path: command code,
  phase lengths, dummy-cycle table, link timing and the phase encoding.
  Assumes a 250 MHz core clock on both ends and a host-made serial clock.
*/
package qfr_pkg;

  // ****************************************
  // command and framing
  // ****************************************
  localparam logic [7:0] QFR_READ_CMD   = 8'hEB;
  localparam int         QFR_ADDR_W     = 24;
  localparam logic [3:0] QFR_CMD_CLK_1  = 4'h8;
  localparam logic [3:0] QFR_CMD_CLK_4  = 4'h2;
  localparam logic [3:0] QFR_ADDR_CLK   = 4'h6;

  // ****************************************
  // dummy cycles per select bits {hi,lo}
  // ****************************************
  localparam logic [3:0] QFR_DUMMY_SEL0 = 4'h6;
  localparam logic [3:0] QFR_DUMMY_SEL1 = 4'h4;
  localparam logic [3:0] QFR_DUMMY_SEL2 = 4'h8;
  localparam logic [3:0] QFR_DUMMY_SEL3 = 4'hA;

  // ****************************************
  // timing
  // ****************************************
  localparam int         QFR_CORE_NS    = 4;
  localparam int         QFR_SCLK_NS    = 48;
  localparam int         QFR_HALF_INT   = QFR_SCLK_NS / (2 * QFR_CORE_NS);
  localparam logic [3:0] QFR_HALF_CYC   = 4'(QFR_HALF_INT);

  // ****************************************
  // transfer phases, used by both ends
  // ****************************************
  typedef enum logic [2:0] {
    QFR_IDLE  = 3'b000,
    QFR_CMD   = 3'b001,
    QFR_ADDR  = 3'b010,
    QFR_DUMMY = 3'b011,
    QFR_DATA  = 3'b100,
    QFR_DONE  = 3'b101
  } qfr_phase_t;

endpackage

// ---- common/qfr_if.sv ----
/*
  Link between host and flash ends: chip select, serial clock and four
  two-way data lines. Resolves the shared lines from both ends' enables.
  Assumes at most one end enables a line at a time; idle lines read high.
*/
`timescale 1ns/1ns
interface qfr_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io_line;

  // lines with no driver float up, modelled as a pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_io_oe[i]) begin
        io_line[i] = dev_io_o[i];
      end else if (host_io_oe[i]) begin
        io_line[i] = host_io_o[i];
      end else begin
        io_line[i] = 1'b1;
      end
    end
  end

  modport host (
    output cs_n,
    output sclk,
    output host_io_o,
    output host_io_oe,
    input  io_line
  );

  modport dev (
    input  cs_n,
    input  sclk,
    input  io_line,
    output dev_io_o,
    output dev_io_oe
  );
endinterface

// ---- rtl/qfr_host.sv ----
/*
  Controller end of the quad I/O read path: makes the serial clock by
  dividing core_clk, sends the read command, address and dummy clocks, then
  gathers bytes from four lines until the user asks it to stop.
  Assumes the flash end shares the same dummy setting as dummy_cycles.
*/
`timescale 1ns/1ns
module qfr_host
  import qfr_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  qfr_if.host                        lnk,
  input  wire logic                  start,
  input  wire logic [QFR_ADDR_W-1:0] start_addr,
  input  wire logic                  use_four_line,
  input  wire logic [3:0]            dummy_cycles,
  input  wire logic                  stop,
  output logic                       busy,
  output logic      [7:0]            rd_data,
  output logic                       rd_valid
);

  // ****************************************
  // return-line synchroniser
  // ****************************************
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      io_s1_q <= lnk.io_line;
      io_s2_q <= io_s1_q;
    end
  end

  // ****************************************
  // clock divider and sequencer
  // ****************************************
  qfr_phase_t  st_q, st_d;
  logic [3:0]  hc_q, hc_d;
  logic        sclk_q, sclk_d;
  logic        cs_n_q, cs_n_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [31:0] sh_q, sh_d;
  logic        four_q, four_d;
  logic        narrow_q, narrow_d;
  logic [3:0]  dum_q, dum_d;
  logic [3:0]  io_o_q, io_o_d;
  logic [3:0]  io_oe_q, io_oe_d;
  logic        nib_hi_q, nib_hi_d;
  logic [3:0]  hi_q, hi_d;
  logic [7:0]  rd_q, rd_d;
  logic        vld_q, vld_d;
  logic        stop_q, stop_d;
  logic        busy_q, busy_d;
  logic        half_end;
  logic        in_xfer;

  assign half_end = (hc_q == QFR_HALF_CYC - 4'h1);
  assign in_xfer  = (st_q != QFR_IDLE) && (st_q != QFR_DONE);

  always_comb begin
    st_d     = st_q;
    sclk_d   = sclk_q;
    cs_n_d   = cs_n_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    four_d   = four_q;
    narrow_d = narrow_q;
    dum_d    = dum_q;
    io_o_d   = io_o_q;
    io_oe_d  = io_oe_q;
    nib_hi_d = nib_hi_q;
    hi_d     = hi_q;
    rd_d     = rd_q;
    vld_d    = 1'b0;
    busy_d   = busy_q;
    stop_d = stop_q | (busy_q & stop);
    hc_d   = (st_q == QFR_IDLE || half_end) ? 4'h0 : hc_q + 4'h1;
    if (st_q == QFR_IDLE) begin
      if (start) begin
        st_d    = QFR_CMD;
        cs_n_d  = 1'b0;
        busy_d  = 1'b1;
        stop_d  = 1'b0;
        cnt_d   = 4'h0;
        sh_d    = {QFR_READ_CMD, start_addr};
        four_d  = use_four_line;
        dum_d   = dummy_cycles;
        io_o_d  = use_four_line ? QFR_READ_CMD[7:4] : {3'b000, QFR_READ_CMD[7]};
        io_oe_d = use_four_line ? 4'hF : 4'h1;
      end
    end else if (st_q == QFR_DONE) begin
      // one half clock of chip select high before the next frame
      if (half_end) begin
        st_d   = QFR_IDLE;
        busy_d = 1'b0;
      end
    end else if (half_end && !sclk_q) begin
      sclk_d   = 1'b1;
      cnt_d    = cnt_q + 4'h1;
      narrow_d = (st_q == QFR_CMD) && !four_q;
      if (st_q == QFR_CMD && cnt_d == (four_q ? QFR_CMD_CLK_4 : QFR_CMD_CLK_1)) begin
        st_d  = QFR_ADDR;
        cnt_d = 4'h0;
      end else if (st_q == QFR_ADDR && cnt_d == QFR_ADDR_CLK) begin
        st_d  = QFR_DUMMY;
        cnt_d = 4'h0;
      end else if (st_q == QFR_DUMMY && cnt_d == dum_q) begin
        st_d     = QFR_DATA;
        cnt_d    = 4'h0;
        nib_hi_d = 1'b1;
      end else if (st_q == QFR_DATA) begin
        // held at one: a data clock has risen, so the next fall carries data
        cnt_d = 4'h1;
      end
    end else if (half_end && in_xfer) begin
      // lines change only on the fall so the flash sees them stable at the rise
      sclk_d = 1'b0;
      if (st_q == QFR_CMD || st_q == QFR_ADDR) begin
        sh_d = narrow_q ? {sh_q[30:0], 1'b0} : {sh_q[27:0], 4'h0};
        if (st_q == QFR_CMD && !four_q) begin
          io_o_d = {3'b000, sh_d[31]};
        end else begin
          io_o_d  = sh_d[31:28];
          io_oe_d = 4'hF;
        end
      end else begin
        io_oe_d = 4'h0;
      end
      // the fall right after the last dummy rise only launches the first nibble
      if (st_q == QFR_DATA && cnt_q != 4'h0) begin
        // late capture: the nibble has stood most of a period by now
        nib_hi_d = ~nib_hi_q;
        if (nib_hi_q) begin
          hi_d = io_s2_q;
        end else begin
          rd_d  = {hi_q, io_s2_q};
          vld_d = 1'b1;
          if (stop_d) begin
            st_d   = QFR_DONE;
            cs_n_d = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q     <= QFR_IDLE;
      hc_q     <= 4'h0;
      sclk_q   <= 1'b0;
      cs_n_q   <= 1'b1;
      cnt_q    <= 4'h0;
      sh_q     <= 32'h0000_0000;
      four_q   <= 1'b0;
      narrow_q <= 1'b0;
      dum_q    <= QFR_DUMMY_SEL0;
      io_o_q   <= 4'h0;
      io_oe_q  <= 4'h0;
      nib_hi_q <= 1'b1;
      hi_q     <= 4'h0;
      rd_q     <= 8'h00;
      vld_q    <= 1'b0;
      stop_q   <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      hc_q     <= hc_d;
      sclk_q   <= sclk_d;
      cs_n_q   <= cs_n_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      four_q   <= four_d;
      narrow_q <= narrow_d;
      dum_q    <= dum_d;
      io_o_q   <= io_o_d;
      io_oe_q  <= io_oe_d;
      nib_hi_q <= nib_hi_d;
      hi_q     <= hi_d;
      rd_q     <= rd_d;
      vld_q    <= vld_d;
      stop_q   <= stop_d;
      busy_q   <= busy_d;
    end
  end

  assign lnk.cs_n       = cs_n_q;
  assign lnk.sclk       = sclk_q;
  assign lnk.host_io_o  = io_o_q;
  assign lnk.host_io_oe = io_oe_q;
  assign busy           = busy_q;
  assign rd_data        = rd_q;
  assign rd_valid       = vld_q;

endmodule

// ---- testbench/qfr_link_monitor.sv ----
/*
  Checker for the link between host and flash ends of the quad read path.
  Assumes sclk is made by the host from core_clk, so it is sampled directly.
*/
`timescale 1ns/1ns
module qfr_link_monitor
  import qfr_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io_line
);
  // ****************************************
  // frame tracking
  // ****************************************
  logic       sclk_q;
  logic       cs_q;
  logic       four_q;
  logic       four_d;
  logic [5:0] rise_q;
  logic [5:0] rise_d;
  logic [5:0] cmd_clks;

  // rise count saturates so a long stream cannot wrap into the early phases
  always_comb begin
    rise_d   = rise_q;
    four_d   = four_q;
    cmd_clks = four_q ? 6'h02 : 6'h08;
    if (cs_n) begin
      rise_d = 6'h00;
    end else if (sclk && !sclk_q && rise_q != 6'h3F) begin
      rise_d = rise_q + 6'h01;
    end
    if (!cs_n && cs_q) begin
      four_d = (host_io_oe == 4'hF);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      rise_q <= 6'h00;
      four_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
      rise_q <= rise_d;
      four_q <= four_d;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_cs_ends_drive: assert property (
    $rose(cs_n) |-> ##[0:8] (dev_io_oe == 4'h0)) else $error("device still drives after cs");
  chk_sclk_high_six: assert property (
    $rose(sclk) |-> sclk[*6] ##1 !sclk) else $error("sclk high half not six cycles");
  chk_sclk_framed: assert property (
    $rose(sclk) |-> !cs_n) else $error("sclk pulse outside a frame");
  chk_host_hold: assert property (
    sclk && $past(sclk) |-> $stable(host_io_o) && $stable(host_io_oe))
    else $error("host lines moved while sclk high");
  chk_dev_hold: assert property (
    sclk && $past(sclk) |-> $stable(dev_io_o) && $stable(dev_io_oe))
    else $error("device lines moved while sclk high");
  chk_cmd_first: assert property (
    $fell(cs_n) |-> (host_io_oe == 4'h1 && host_io_o[0] == QFR_READ_CMD[7]) ||
      (host_io_oe == 4'hF && host_io_o == QFR_READ_CMD[7:4]))
    else $error("wrong first command bits");
  chk_addr_quad: assert property (
    sclk && sclk_q && rise_q > cmd_clks && rise_q <= cmd_clks + 6'h06 |->
      host_io_oe == 4'hF) else $error("address not on four lines");
  chk_dev_quiet: assert property (
    !cs_n && rise_q < cmd_clks + 6'h0A |-> dev_io_oe == 4'h0)
    else $error("device drove before dummy end");
  chk_no_contend: assert property (
    (dev_io_oe & host_io_oe) == 4'h0) else $error("both ends drive a line");
  chk_dev_width: assert property (
    dev_io_oe == 4'h0 || dev_io_oe == 4'hF) else $error("device drives partial width");
  chk_line_follows: assert property (
    dev_io_oe == 4'hF |-> io_line == dev_io_o) else $error("lines differ from device drive");

  cov_four_line: cover property ($rose(dev_io_oe[0]) && four_q);
  cov_single: cover property ($rose(dev_io_oe[0]) && !four_q);
  cov_stop_data: cover property ($rose(cs_n) && dev_io_oe == 4'hF);
endmodule

// ---- testbench/test_quad_io_flash_read_path.sv ----
/*
  Self-checking bench: host and flash ends joined by the link, with a bench
  array model behind the flash end. Assumes no other master on the link.
*/
`timescale 1ns/1ns
module test_quad_io_flash_read_path
  import qfr_pkg::*;
;
  // ****************************************
  // signals and ends
  // ****************************************
  logic                  core_clk;
  logic                  rst;
  logic                  start;
  logic [QFR_ADDR_W-1:0] start_addr;
  logic                  use_four_line;
  logic [3:0]            dummy_cycles;
  logic                  stop;
  logic                  busy;
  logic [7:0]            rd_data;
  logic                  rd_valid;
  logic                  quad_enable_bit;
  logic                  four_line_command_mode;
  logic                  dummy_select_lo;
  logic                  dummy_select_hi;
  logic                  write_busy;
  logic [7:0]            mem_data;
  logic [QFR_ADDR_W-1:0] mem_addr;
  logic                  read_active;
  logic                  cmd_reject;
  int                    errors;
  int                    tests_run;
  int                    got_bytes;
  int                    want_bytes;

  qfr_if lnk ();

  qfr_host u_qfr_host (.core_clk(core_clk), .rst(rst), .lnk(lnk), .start(start),
    .start_addr(start_addr), .use_four_line(use_four_line), .dummy_cycles(dummy_cycles),
    .stop(stop), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid));

  qfr_dev u_qfr_dev (.core_clk(core_clk), .rst(rst), .lnk(lnk),
    .quad_enable_bit(quad_enable_bit), .four_line_command_mode(four_line_command_mode),
    .dummy_select_lo(dummy_select_lo), .dummy_select_hi(dummy_select_hi),
    .write_busy(write_busy), .mem_data(mem_data), .mem_addr(mem_addr),
    .read_active(read_active), .cmd_reject(cmd_reject));

  qfr_link_monitor u_qfr_link_monitor (.core_clk(core_clk), .rst(rst), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .host_io_o(lnk.host_io_o), .host_io_oe(lnk.host_io_oe),
    .dev_io_o(lnk.dev_io_o), .dev_io_oe(lnk.dev_io_oe), .io_line(lnk.io_line));

  // ****************************************
  // array model and helpers
  // ****************************************
  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction

  function automatic logic [3:0] dummy_of(input logic [1:0] s);
    case (s)
      2'b00: return QFR_DUMMY_SEL0;
      2'b01: return QFR_DUMMY_SEL1;
      2'b10: return QFR_DUMMY_SEL2;
      default: return QFR_DUMMY_SEL3;
    endcase
  endfunction

  always #2 core_clk = ~core_clk;

  // one cycle of array latency, as the flash end allows
  always @(posedge core_clk) begin
    mem_data <= exp_byte(mem_addr);
    stop     <= busy && (got_bytes >= want_bytes);
  end

  task automatic check(input logic c, input string msg);
    tests_run++;
    if (c !== 1'b1) begin
      errors++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // one read; a refused read is stopped after the host's second byte
  // ****************************************
  task automatic run_read(input logic [23:0] a, input logic f, input logic [1:0] s,
                          input int n, input logic qe, input logic wb);
    logic ok;
    logic rej;
    logic act;
    int   k;
    ok = qe && !wb;
    rej = 1'b0;
    act = 1'b0;
    got_bytes = 0;
    want_bytes = n;
    @(posedge core_clk);
    quad_enable_bit <= qe;
    write_busy <= wb;
    four_line_command_mode <= f;
    {dummy_select_hi, dummy_select_lo} <= s;
    use_four_line <= f;
    dummy_cycles <= dummy_of(s);
    start_addr <= a;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    for (k = 0; k < 4000; k++) begin
      @(negedge core_clk);
      if (cmd_reject === 1'b1) rej = 1'b1;
      if (read_active === 1'b1) act = 1'b1;
      if (rd_valid === 1'b1) begin
        if (ok) check(rd_data === exp_byte(24'(a + got_bytes)), "read byte mismatch");
        got_bytes++;
      end
      if (busy === 1'b0 && k > 2) break;
    end
    check(k < 4000, "read did not finish");
    check(rej === !ok, "reject pulse wrong");
    check(act === ok, "data phase entry wrong");
    check(!ok || got_bytes >= n, "too few bytes");
    check(lnk.cs_n === 1'b1 && lnk.dev_io_oe === 4'h0, "link not released");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    start_addr = 24'h00_0000;
    use_four_line = 1'b0;
    dummy_cycles = QFR_DUMMY_SEL0;
    quad_enable_bit = 1'b1;
    four_line_command_mode = 1'b0;
    dummy_select_lo = 1'b0;
    dummy_select_hi = 1'b0;
    write_busy = 1'b0;
    errors = 0;
    tests_run = 0;
    got_bytes = 0;
    want_bytes = 1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    void'($urandom(32'h2606));
    // every dummy select in both command modes
    for (int m = 0; m < 8; m++) begin
      run_read(24'($urandom), m[2], m[1:0], 2 + int'($urandom % 3), 1'b1, 1'b0);
    end
    run_read(24'hFF_FFFE, 1'b0, 2'b01, 4, 1'b1, 1'b0);
    run_read(24'hFF_FFFF, 1'b1, 2'b11, 3, 1'b1, 1'b0);
    run_read(24'($urandom), 1'b0, 2'b00, 1, 1'b0, 1'b0);
    run_read(24'($urandom), 1'b1, 2'b10, 1, 1'b1, 1'b1);
    run_read(24'($urandom), 1'b0, 2'b00, 1, 1'b1, 1'b1);
    run_read(24'h00_0000, 1'b1, 2'b00, 1, 1'b1, 1'b0);
    test_done();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
